// ---- core/uoxb_consts.svh ----
// offsets, field positions, reset values and bus codes of the out x buffer block
`ifndef UOXB_CONSTS_SVH
`define UOXB_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define UOXB_OFS_COUNT 4'h0
`define UOXB_OFS_SIZE 4'h4
`define UOXB_OFS_BASE 4'h8
`define UOXB_OFS_CONFIG 4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UOXB_CNT_HELD_BIT 7
`define UOXB_CNF_ENABLE_BIT 7
`define UOXB_CNF_ISO_BIT 6
`define UOXB_CNF_DOUBLE_BIT 4
`define UOXB_CNF_BPS_MSB 2
`define UOXB_CNF_BPS_LSB 0
`define UOXB_BASE_LSB 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UOXB_RST_COUNT 8'h00
`define UOXB_RST_SIZE 8'h00
`define UOXB_RST_BASE 8'h00
`define UOXB_RST_CONFIG 8'h00

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define UOXB_RESP_OKAY 2'b00
`define UOXB_RESP_SLVERR 2'b10

`endif

// ---- core/uoxb_pkg.sv ----
// types shared by the out x buffer block
`default_nettype none
package uoxb_pkg;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_DATA = 2'b01,
        RX_DROP = 2'b10
    } uoxb_rx_state_e;

endpackage

`default_nettype wire

// ---- core/uoxb_ctrl.sv ----
// out endpoint x buffer control: registers, packet receive and buffer write
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "uoxb_consts.svh"

module uoxb_ctrl
    import uoxb_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // received out packet from serial engine
    input wire logic rx_start,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_end,
    input wire logic rx_good,
    // handshake decision
    output logic rx_accept,
    output logic hs_ack,
    output logic hs_nak,
    // buffer memory write port
    output logic mem_we,
    output logic [10:0] mem_addr,
    output logic [7:0] mem_wdata,
    // endpoint mode
    output logic ep_iso,
    output logic ep_double_buffer
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // counts saturate so an oversize packet never wraps to a small count
    function automatic logic [6:0] sat_inc7(input logic [6:0] v);
        sat_inc7 = (v == 7'h7f) ? v : v + 7'h01;
    endfunction

    // ----------------------------------------------------------------
    // registers and derived values
    // ----------------------------------------------------------------
    logic held_q;
    logic [6:0] count_q;
    logic [7:0] size_q;
    logic [7:0] base_q;
    logic [7:0] cfg_q;
    logic ep_enable;
    logic [2:0] bps_m1;
    logic [10:0] buf_len;
    logic [10:0] x_start;

    assign ep_enable = cfg_q[`UOXB_CNF_ENABLE_BIT];
    assign ep_iso = cfg_q[`UOXB_CNF_ISO_BIT];
    assign ep_double_buffer = cfg_q[`UOXB_CNF_DOUBLE_BIT];
    // low bits mean bytes per sample only for iso
    assign bps_m1 = ep_iso ? cfg_q[`UOXB_CNF_BPS_MSB:`UOXB_CNF_BPS_LSB] : 3'h0;
    assign buf_len = {size_q, 3'b000};
    assign x_start = {base_q, 3'b000};

    // ----------------------------------------------------------------
    // axi write channel
    // ----------------------------------------------------------------
    logic aw_held_q;
    logic [3:0] awaddr_q;
    logic w_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_go;
    logic wr_lane0;
    logic wr_map;

    assign s_axi_awready = ce && !aw_held_q && !bvalid_q;
    assign s_axi_wready = ce && !w_held_q && !bvalid_q;
    assign wr_go = ce && aw_held_q && w_held_q && !bvalid_q;
    assign wr_lane0 = wr_go && wstrb_q[0];
    assign wr_map = (awaddr_q[1:0] == 2'b00);
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `UOXB_RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_map ? `UOXB_RESP_OKAY : `UOXB_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_arready = ce && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `UOXB_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rresp_q <= `UOXB_RESP_OKAY;
                unique case (s_axi_araddr)
                    `UOXB_OFS_COUNT: rdata_q <= {24'h00_0000, held_q, count_q};
                    `UOXB_OFS_SIZE: rdata_q <= {24'h00_0000, size_q};
                    `UOXB_OFS_BASE: rdata_q <= {24'h00_0000, base_q};
                    `UOXB_OFS_CONFIG: rdata_q <= {24'h00_0000, cfg_q};
                    default: begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= `UOXB_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // software-only registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            size_q <= `UOXB_RST_SIZE;
            base_q <= `UOXB_RST_BASE;
            cfg_q <= `UOXB_RST_CONFIG;
        end else if (ce && wr_lane0) begin
            if (awaddr_q == `UOXB_OFS_SIZE) begin
                size_q <= wdata_q[7:0];
            end
            if (awaddr_q == `UOXB_OFS_BASE) begin
                base_q <= wdata_q[7:0];
            end
            if (awaddr_q == `UOXB_OFS_CONFIG) begin
                cfg_q <= wdata_q[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // packet receive
    // ----------------------------------------------------------------
    uoxb_rx_state_e state_q;
    logic [10:0] off_q;
    logic [6:0] byte_cnt_q;
    logic [6:0] samp_cnt_q;
    logic [2:0] phase_q;
    logic pkt_done;
    logic room;

    // a held packet locks out non-iso traffic until software frees it
    assign rx_accept = ep_enable && (ep_iso || !held_q);
    assign pkt_done = ce && (state_q == RX_DATA) && rx_end && rx_good;
    assign room = off_q < buf_len;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= RX_IDLE;
        end else if (ce) begin
            unique case (state_q)
                RX_IDLE: begin
                    if (rx_start) begin
                        state_q <= rx_accept ? RX_DATA : RX_DROP;
                    end
                end
                RX_DATA, RX_DROP: begin
                    if (rx_end) begin
                        state_q <= RX_IDLE;
                    end
                end
                default: state_q <= RX_IDLE;
            endcase
        end
    end

    // byte and sample counting; partial trailing sample is not counted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            off_q <= 11'h000;
            byte_cnt_q <= 7'h00;
            samp_cnt_q <= 7'h00;
            phase_q <= 3'h0;
        end else if (ce) begin
            if (state_q == RX_IDLE) begin
                off_q <= 11'h000;
                byte_cnt_q <= 7'h00;
                samp_cnt_q <= 7'h00;
                phase_q <= 3'h0;
            end else if (state_q == RX_DATA && rx_valid && room) begin
                off_q <= off_q + 11'h001;
                byte_cnt_q <= sat_inc7(byte_cnt_q);
                if (phase_q == bps_m1) begin
                    phase_q <= 3'h0;
                    samp_cnt_q <= sat_inc7(samp_cnt_q);
                end else begin
                    phase_q <= phase_q + 3'h1;
                end
            end
        end
    end

    // bytes beyond the buffer are dropped rather than spilling into neighbours
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_we <= 1'b0;
            mem_addr <= 11'h000;
            mem_wdata <= 8'h00;
        end else if (ce) begin
            mem_we <= (state_q == RX_DATA) && rx_valid && room;
            if ((state_q == RX_DATA) && rx_valid && room) begin
                mem_addr <= x_start + off_q;
                mem_wdata <= rx_byte;
            end
        end
    end

    // ----------------------------------------------------------------
    // handshakes
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_ack <= 1'b0;
            hs_nak <= 1'b0;
        end else if (ce) begin
            hs_nak <= (state_q == RX_IDLE) && rx_start && ep_enable && !ep_iso && held_q;
            hs_ack <= pkt_done && !ep_iso;
        end
    end

    // ----------------------------------------------------------------
    // count register: hardware load wins over a software write
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {held_q, count_q} <= `UOXB_RST_COUNT;
        end else if (ce) begin
            if (pkt_done) begin
                held_q <= 1'b1;
                count_q <= ep_iso ? samp_cnt_q : byte_cnt_q;
            end else if (wr_lane0 && awaddr_q == `UOXB_OFS_COUNT) begin
                held_q <= wdata_q[`UOXB_CNT_HELD_BIT];
                count_q <= wdata_q[6:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    held_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pkt_done |=> held_q)
        else $error("held flag not set after good packet");
    nak_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && state_q == RX_IDLE && rx_start && ep_enable && !ep_iso && held_q)
        |=> hs_nak && !hs_ack)
        else $error("held non-iso endpoint did not nak");
    held_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && state_q == RX_IDLE && rx_start && !ep_iso && held_q) |=> state_q == RX_DROP)
        else $error("packet taken while held");
    iso_no_nak_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && ep_iso && state_q == RX_IDLE && rx_start && ep_enable) |=> !hs_nak && state_q == RX_DATA)
        else $error("iso endpoint refused a packet");
    byte_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pkt_done && !ep_iso) |=> count_q == $past(byte_cnt_q))
        else $error("byte count not loaded");
    samp_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pkt_done && ep_iso) |=> count_q == $past(samp_cnt_q))
        else $error("sample count not loaded");
    size_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_lane0 && awaddr_q == `UOXB_OFS_SIZE) |=> size_q == $past(wdata_q[7:0]) && s_axi_bvalid)
        else $error("size write lost");
    first_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && state_q == RX_DATA && rx_valid && room && off_q == 11'h000)
        |=> mem_we && mem_addr == {$past(base_q), 3'b000})
        else $error("first byte not at aligned base");
    no_overrun_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mem_we |-> $past(off_q) < {$past(size_q), 3'b000})
        else $error("write beyond buffer length");

endmodule // uoxb_ctrl

`default_nettype wire

// ---- tb/uoxb_host_model.sv ----
// host side model: drives out transactions into the endpoint receive port
`timescale 1ns/10ps
`default_nettype none

module uoxb_host_model (
    // clock
    input wire logic aclk,
    // receive port towards the endpoint
    output var logic rx_start,
    output var logic rx_valid,
    output var logic [7:0] rx_byte,
    output var logic rx_end,
    output var logic rx_good
);
    initial begin
        {rx_start, rx_valid, rx_end, rx_good} = 4'h0;
        rx_byte = 8'h00;
    end

    // slow adds an idle cycle after every byte; the idle byte lane is
    // inverted so a stale value can never pass for the next byte
    task automatic send(input logic [7:0] d [16], input int n, input logic good,
                        input logic slow);
        @(posedge aclk);
        rx_start <= 1'b1;
        for (int k = 0; k < n; k++) begin
            @(posedge aclk);
            rx_start <= 1'b0;
            rx_valid <= 1'b1;
            rx_byte <= d[k];
            if (slow) begin
                @(posedge aclk);
                rx_valid <= 1'b0;
                rx_byte <= ~d[k];
            end
        end
        @(posedge aclk);
        rx_start <= 1'b0;
        rx_valid <= 1'b0;
        rx_byte <= rx_byte + 8'h5b;
        rx_end <= 1'b1;
        rx_good <= good;
        @(posedge aclk);
        rx_end <= 1'b0;
        rx_good <= 1'b0;
    endtask
endmodule // uoxb_host_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the out endpoint x buffer control
`timescale 1ns/10ps
`default_nettype none
`include "uoxb_consts.svh"

module tb;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic rx_start, rx_valid, rx_end, rx_good, rx_accept, hs_ack, hs_nak;
    logic [7:0] rx_byte, mem_wdata, pk [16];
    logic mem_we, ep_iso, ep_double_buffer;
    logic [10:0] mem_addr;
    logic [33:0] exp_axi [$];
    logic [18:0] exp_mem [$];
    logic [1:0] exp_hs [$];
    logic [7:0] m_cfg = 8'h00, m_size = 8'h00, m_base = 8'h00;
    logic m_held = 1'b0;
    logic [6:0] m_cnt = 7'h00;
    int seed = 66368;
    int fail_count = 0;
    int comparisons = 0;

    always #5 aclk = ~aclk;

    uoxb_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
        .rx_good(rx_good), .rx_accept(rx_accept), .hs_ack(hs_ack), .hs_nak(hs_nak),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .ep_iso(ep_iso), .ep_double_buffer(ep_double_buffer));

    uoxb_host_model u_host (.aclk(aclk), .rx_start(rx_start), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_end(rx_end), .rx_good(rx_good));

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // bus master; readies are sampled mid-cycle, where they are settled
    // ----------------------------------------------------------------
    task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ta, tw, tv;
        exp_axi.push_back({r, 32'h0});
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'($random(seed)), d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tv = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tv);
        bready <= 1'b0;
        case (a)
            `UOXB_OFS_COUNT: {m_held, m_cnt} = d;
            `UOXB_OFS_SIZE: m_size = d;
            `UOXB_OFS_BASE: m_base = d;
            `UOXB_OFS_CONFIG: m_cfg = d;
            default: ;
        endcase
    endtask

    task automatic axr(input logic [3:0] a, input logic [33:0] e);
        logic ta, tv;
        exp_axi.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            tv = rvalid;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tv);
        rready <= 1'b0;
    endtask

    task automatic rd_count();
        axr(`UOXB_OFS_COUNT, {`UOXB_RESP_OKAY, 24'h0, m_held, m_cnt});
    endtask

    // reference model of one out transaction
    task automatic pkt(input int n, input logic good, input logic slow);
        logic iso, acc;
        iso = m_cfg[6];
        acc = m_cfg[7] && (iso || !m_held);
        @(negedge aclk);
        check(34'(rx_accept), 34'(acc));
        for (int k = 0; k < 16; k++) pk[k] = 8'($random(seed));
        if (m_cfg[7] && !iso && m_held) exp_hs.push_back(2'b10);
        for (int k = 0; k < n; k++)
            if (acc && k < int'(m_size) * 8) exp_mem.push_back({{m_base, 3'b000} + 11'(k), pk[k]});
        if (acc && good && !iso) exp_hs.push_back(2'b01);
        u_host.send(pk, n, good, slow);
        if (acc && good) begin
            m_held = 1'b1;
            m_cnt = iso ? 7'(n / (int'(m_cfg[2:0]) + 1)) : 7'(n);
        end
    endtask

    // ----------------------------------------------------------------
    // result watcher
    // ----------------------------------------------------------------
    always @(negedge aclk) begin
        if (bvalid && bready) check({bresp, 32'h0}, exp_axi.size() ? exp_axi.pop_front() : 'x);
        if (rvalid && rready) check({rresp, rdata}, exp_axi.size() ? exp_axi.pop_front() : 'x);
        if (mem_we) check(34'({mem_addr, mem_wdata}), 34'(exp_mem.size() ? exp_mem.pop_front() : 'x));
        if (hs_ack || hs_nak) check(34'({hs_nak, hs_ack}), 34'(exp_hs.size() ? exp_hs.pop_front() : 'x));
    end

    // whole run is well under a thousand cycles
    initial begin
        #300us;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) axr(4'(a), 34'h0);
        axr(4'h2, {`UOXB_RESP_SLVERR, 32'h0});
        axw(4'h6, 8'h11, `UOXB_RESP_SLVERR);
        axw(`UOXB_OFS_SIZE, 8'h01, `UOXB_RESP_OKAY);
        axw(`UOXB_OFS_BASE, 8'($random(seed)), `UOXB_RESP_OKAY);
        axw(`UOXB_OFS_CONFIG, 8'h80, `UOXB_RESP_OKAY);
        axr(`UOXB_OFS_SIZE, {`UOXB_RESP_OKAY, 24'h0, m_size});
        axr(`UOXB_OFS_BASE, {`UOXB_RESP_OKAY, 24'h0, m_base});
        pkt(8, 1'b1, 1'b0);
        rd_count();
        pkt(3, 1'b1, 1'b1);
        rd_count();
        axw(`UOXB_OFS_COUNT, 8'h00, `UOXB_RESP_OKAY);
        pkt(9, 1'b0, 1'b0);
        rd_count();
        axw(`UOXB_OFS_SIZE, 8'h02, `UOXB_RESP_OKAY);
        axw(`UOXB_OFS_CONFIG, 8'hc2, `UOXB_RESP_OKAY);
        check(34'(ep_iso), 34'h1);
        pkt(7, 1'b1, 1'b1);
        rd_count();
        axw(`UOXB_OFS_COUNT, 8'h00, `UOXB_RESP_OKAY);
        pkt(4, 1'b1, 1'b0);
        rd_count();
        axw(`UOXB_OFS_CONFIG, 8'h90, `UOXB_RESP_OKAY);
        check(34'({ep_iso, ep_double_buffer}), 34'h1);
        pkt(5, 1'b1, 1'b0);
        axw(`UOXB_OFS_CONFIG, 8'h10, `UOXB_RESP_OKAY);
        pkt(5, 1'b1, 1'b0);
        rd_count();
        repeat (4) @(posedge aclk);
        check(34'(exp_mem.size() + exp_hs.size() + exp_axi.size()), 34'h0);
        end_sim();
    end
endmodule // tb
`default_nettype wire
